// ---- src/reset_source_controller.sv ----
// Reset source controller: merges the reset sources into one system reset,
// records the last cause and holds the source enables.
// Assumes rst_n is the power-on reset and that the analog clock-loss one-shot,
// comparator and supply monitor deliver levels from outside the clock domain.
`timescale 1ns/100ps
`include "reset_source_defines.svh"

// Notes on behaviour
// - Low reset pin puts device in reset
// - Pin reset sets flag bit 0
// - Clock loss detector times out, resets
// - Clock loss timeout 100 to 500 us
// - Bit 2 reads 1 after clock loss
// - Write bit 2 enables clock loss detector
// - Only power resets drive the pin
// - Write bit 5 enables comparator reset
// - Comparator reset while plus below minus
// - Bit 5 reads 1 after comparator reset
// - Watchdog on, clock divided by twelve
// - Watchdog expiry resets, sets bit 3
// - Flash write above limit resets
// - Table read above limit resets
// - Branch above limit resets
// - Code limit depends on memory size
// - Flash error reset sets bit 6
// - Write bit 4 forces software reset
// - Wait 5 us before executing code
// - Power-on sets bit 1, others clear
// - Write bit 1 enables supply monitor
module reset_source_controller #(
	parameter logic [15:0] USER_CODE_LIMIT = `RSC_LIMIT_8K
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire reset_source_pkg::sfr_req_t    sfr,
	output logic [7:0]                         sfr_rdata,
	input  wire reset_source_pkg::mem_access_t mem,
	input  wire logic                          flash_write_enable,
	input  wire logic                          rst_pin_in,
	output logic                               rst_pin_out,
	output logic                               rst_pin_oe_n,
	input  wire logic                          clock_loss_timeout,
	input  wire logic                          comparator_out,
	input  wire logic                          supply_low,
	input  wire logic                          wdog_expired,
	input  wire logic                          wdog_disable,
	output logic                               wdog_enable,
	output logic                               wdog_tick,
	output logic                               clock_loss_enable,
	output logic                               supply_monitor_enable,
	output logic                               sys_rst_n
);
	import reset_source_pkg::*;

	localparam logic [6:0] DELAY_LAST = 7'(`RSC_EXEC_DELAY_CYC - 1);
	localparam logic [3:0] DIV_LAST   = 4'(`RSC_WDOG_DIV - 1);

	// Reset value of the whole state record
	localparam rsc_state_t STATE_RST = '{
		ph:         PH_HOLD,
		flags:      7'h02,
		cnt:        7'h00,
		sy:         12'h1C7, // Pin and comparator idle high, others low
		lvl:        4'h5,
		mon_en:     `RSC_MON_EN_RST,
		clkloss_en: `RSC_CLKLOSS_EN_RST,
		comp_en:    `RSC_COMP_EN_RST,
		wdog_en:    1'b1,
		div:        4'h0,
		wdog_tick:  1'b0,
		sys_rst_n:  1'b0,
		pin_oe_n:   1'b0,
		pin_out:    1'b0,
		rdata:      8'h00
	};

	logic [1:0]   rst_sync;
	logic         rst_sync_n;
	rsc_state_t   s_r;
	rsc_state_t   s_nxt;
	logic [3:0]   raw_in;
	logic         pin_act;
	logic         mon_act;
	logic         comp_act;
	logic         loss_act;
	logic         level_act;
	logic         flash_err;
	logic         soft_req;
	logic         wdog_req;
	logic         reg_wr;
	logic         any_req;
	cause_flags_t new_cause;

	// Power-on reset release through two flops, assert stays asynchronous
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync[1];

	// Raw outside levels: 0 pin, 1 supply, 2 comparator, 3 clock loss
	assign raw_in = {clock_loss_timeout, comparator_out, supply_low, rst_pin_in};

	// Level sources; own pin drive is ignored so it cannot look like a pin reset
	assign pin_act   = !s_r.lvl[0] && s_r.pin_oe_n;
	assign mon_act   = s_r.lvl[1] && s_r.mon_en;
	assign comp_act  = !s_r.lvl[2] && s_r.comp_en;
	// The one-shot itself times the 100 to 500 us window
	assign loss_act  = s_r.lvl[3] && s_r.clkloss_en;
	assign level_act = pin_act | mon_act | comp_act | loss_act;

	// Event sources, only while the core runs
	assign flash_err = (s_r.ph == PH_RUN) && (
		(mem.external_data_move_instr_req && flash_write_enable && mem.external_data_move_instr_addr > USER_CODE_LIMIT) ||
		(mem.code_table_read_instr_req && mem.code_table_read_instr_addr > USER_CODE_LIMIT) ||
		(mem.fetch_req && mem.fetch_addr > USER_CODE_LIMIT));
	assign reg_wr   = (s_r.ph == PH_RUN) && sfr.wr && (sfr.addr == `RSC_REG_ADDR);
	assign soft_req = reg_wr && sfr.wdata[`RSC_BIT_SOFT];
	assign wdog_req = (s_r.ph == PH_RUN) && wdog_expired;
	assign any_req  = level_act | flash_err | soft_req | wdog_req;

	// One-hot cause; supply loss outranks everything since data may be lost
	always_comb begin
		new_cause = '0;
		if (mon_act) begin
			new_cause.power_on_flag_monitor_enable = 1'b1;
		end else if (pin_act) begin
			new_cause.pin_reset_flag = 1'b1;
		end else if (loss_act) begin
			new_cause.clock_loss_flag_enable = 1'b1;
		end else if (comp_act) begin
			new_cause.comparator_reset_flag_enable = 1'b1;
		end else if (wdog_req) begin
			new_cause.watchdog_reset_flag = 1'b1;
		end else if (flash_err) begin
			new_cause.flash_error_flag = 1'b1;
		end else if (soft_req) begin
			new_cause.software_reset_force_flag = 1'b1;
		end
	end

	// Next state of the whole controller
	always_comb begin
		s_nxt = s_r;
		s_nxt.wdog_tick = 1'b0;
		// Three-stage sync; a change counts once stages two and three agree
		for (int i = 0; i < 4; i++) begin
			s_nxt.sy[i] = {s_r.sy[i][1:0], raw_in[i]};
			if (s_r.sy[i][2] == s_r.sy[i][1]) begin
				s_nxt.lvl[i] = s_r.sy[i][2];
			end
		end
		// Own drive keeps the pin copy idle, else release looks like a pin reset
		if (!s_r.pin_oe_n) begin
			s_nxt.sy[0]  = 3'b111;
			s_nxt.lvl[0] = 1'b1;
		end
		// Register read shows the last cause
		if (sfr.rd && sfr.addr == `RSC_REG_ADDR) begin
			s_nxt.rdata = {1'b0, s_r.flags};
		end
		unique case (s_r.ph)
			PH_RUN: begin
				if (any_req) begin
					s_nxt.ph    = PH_HOLD;
					s_nxt.flags = new_cause;
				end else if (reg_wr) begin
					// Monitor enable is set-only; clearing needs a power-on
					if (sfr.wdata[`RSC_BIT_POWER]) begin
						s_nxt.mon_en = 1'b1;
					end
					s_nxt.clkloss_en = sfr.wdata[`RSC_BIT_CLKLOSS];
					s_nxt.comp_en    = sfr.wdata[`RSC_BIT_COMP];
				end
			end
			PH_HOLD: begin
				// Stay while any level source is still asserted
				if (!level_act) begin
					s_nxt.ph  = PH_DELAY;
					s_nxt.cnt = 7'h00;
				end
			end
			PH_DELAY: begin
				if (level_act) begin
					s_nxt.ph    = PH_HOLD;
					s_nxt.flags = new_cause;
				end else if (s_r.cnt == DELAY_LAST) begin
					s_nxt.ph = PH_RUN;
				end else begin
					s_nxt.cnt = s_r.cnt + 7'h01;
				end
			end
		endcase
		// Watchdog re-armed by every reset, divider restarts
		if (s_nxt.ph != PH_RUN) begin
			s_nxt.wdog_en = 1'b1;
			s_nxt.div     = 4'h0;
		end else begin
			if (wdog_disable) begin
				s_nxt.wdog_en = 1'b0;
			end
			if (s_r.div == DIV_LAST) begin
				s_nxt.div       = 4'h0;
				s_nxt.wdog_tick = s_r.wdog_en;
			end else begin
				s_nxt.div = s_r.div + 4'h1;
			end
		end
		// Pin driven low only for power related resets until code runs
		s_nxt.sys_rst_n = (s_nxt.ph == PH_RUN);
		s_nxt.pin_oe_n  = !((s_nxt.ph != PH_RUN) &&
			s_nxt.flags.power_on_flag_monitor_enable);
		s_nxt.pin_out   = 1'b0;
	end

	// State register; async clear gives the power-on cause
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state flops
	assign sfr_rdata             = s_r.rdata;
	assign rst_pin_out           = s_r.pin_out;
	assign rst_pin_oe_n          = s_r.pin_oe_n;
	assign wdog_enable           = s_r.wdog_en;
	assign wdog_tick             = s_r.wdog_tick;
	assign clock_loss_enable     = s_r.clkloss_en;
	assign supply_monitor_enable = s_r.mon_en;
	assign sys_rst_n             = s_r.sys_rst_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	// Named steps of a reset sequence
	sequence seq_enter_hold;
		(s_r.ph == PH_HOLD) && !sys_rst_n;
	endsequence

	sequence seq_hold_to_delay;
		(s_r.ph == PH_HOLD) ##1 (s_r.ph == PH_DELAY);
	endsequence

	chk_pin_enters_reset: assert property (
		(s_r.ph == PH_RUN && pin_act) |=> seq_enter_hold)
		else $error("pin low did not enter reset");

	chk_pin_flag_only: assert property (
		(s_r.ph == PH_RUN && pin_act && !mon_act) |=> (s_r.flags == 7'h01))
		else $error("pin reset flag wrong");

	chk_clkloss_flag: assert property (
		(s_r.ph == PH_RUN && loss_act && !pin_act && !mon_act)
		|=> (s_r.flags == 7'h04) ##0 seq_enter_hold)
		else $error("clock loss reset flag wrong");

	chk_pin_undriven: assert property (
		!s_r.flags.power_on_flag_monitor_enable |-> rst_pin_oe_n)
		else $error("pin driven for a non-power reset");

	chk_comp_enable: assert property (
		(reg_wr && !any_req) |=> (s_r.comp_en == $past(sfr.wdata[5]))
		&& (clock_loss_enable == $past(sfr.wdata[2])))
		else $error("enable bits not taken from write");

	chk_soft_force: assert property (
		(soft_req && !level_act && !wdog_req && !flash_err)
		|=> seq_enter_hold ##0 s_r.flags.software_reset_force_flag ##1 (s_r.ph == PH_DELAY))
		else $error("software reset not forced");

	chk_exec_delay: assert property (
		seq_hold_to_delay |-> !sys_rst_n [*8] ##0 (s_r.cnt == 7'h07 || level_act
		|| s_r.ph == PH_HOLD))
		else $error("code ran before reset delay");

	chk_release_count: assert property (
		$rose(sys_rst_n) |-> ($past(s_r.cnt) == DELAY_LAST))
		else $error("release not at end of delay");

	chk_wdog_rearmed: assert property (
		!sys_rst_n |-> wdog_enable && !wdog_tick)
		else $error("watchdog not enabled in reset");

	chk_flash_flag: assert property (
		(flash_err && !level_act && !wdog_req) |=> (s_r.flags == 7'h40))
		else $error("flash error flag wrong");

	chk_bit7_zero: assert property (
		sfr_rdata[7] == 1'b0)
		else $error("reserved bit reads one");

	// Release followed by the cycles up to the first divider wrap
	sequence seq_release_run;
		$rose(sys_rst_n) ##11 sys_rst_n;
	endsequence

	chk_comp_flag: assert property (
		(s_r.ph == PH_RUN && comp_act && !pin_act && !mon_act && !loss_act)
		|=> (s_r.flags == 7'h20) ##0 seq_enter_hold)
		else $error("comparator reset flag wrong");

	chk_wdog_flag: assert property (
		(wdog_req && !level_act) |=> (s_r.flags == 7'h08) ##0 seq_enter_hold)
		else $error("watchdog reset flag wrong");

	chk_first_tick: assert property (
		seq_release_run ##0 wdog_enable |-> wdog_tick)
		else $error("watchdog tick late after release");

	chk_tick_spacing: assert property (
		wdog_tick |=> (!wdog_tick) [*8])
		else $error("watchdog ticks too close");

	chk_monitor_sticky: assert property (
		supply_monitor_enable |=> supply_monitor_enable)
		else $error("supply monitor enable lost");

	chk_power_cleared: assert property (
		(s_r.ph == PH_RUN && any_req && !mon_act)
		|=> !s_r.flags.power_on_flag_monitor_enable)
		else $error("power flag kept by other reset");

	chk_soft_zero: assert property (
		(reg_wr && !sfr.wdata[`RSC_BIT_SOFT] && !level_act && !flash_err && !wdog_req)
		|=> sys_rst_n)
		else $error("zero write forced a reset");

	chk_hold_while_low: assert property (
		(s_r.ph == PH_HOLD && level_act) |=> (s_r.ph == PH_HOLD))
		else $error("reset left while a source is active");

	chk_rdata_stands: assert property (
		!(sfr.rd && sfr.addr == `RSC_REG_ADDR) |=> $stable(sfr_rdata))
		else $error("read data changed without a read");

endmodule // reset_source_controller

// ---- src/reset_source_defines.svh ----
// Constants for the reset source controller: register address, bit positions,
// reset values and timing counts. Assumes a 20 MHz system clock.
`ifndef RESET_SOURCE_DEFINES_SVH
`define RESET_SOURCE_DEFINES_SVH

// Register address in the special-function space
`define RSC_REG_ADDR        8'hEF

// Bit positions inside the reset cause register
`define RSC_BIT_PIN         0
`define RSC_BIT_POWER       1
`define RSC_BIT_CLKLOSS     2
`define RSC_BIT_WDOG        3
`define RSC_BIT_SOFT        4
`define RSC_BIT_COMP        5
`define RSC_BIT_FLASH       6

// Clock period and documented times
`define RSC_CLK_PERIOD_NS   50
`define RSC_EXEC_DELAY_NS   5000
`define RSC_PIN_LOW_MIN_NS  15000
`define RSC_CLKLOSS_MIN_NS  100000
`define RSC_CLKLOSS_TYP_NS  220000
`define RSC_CLKLOSS_MAX_NS  500000

// Least time rounds up to whole cycles
`define RSC_EXEC_DELAY_CYC  ((`RSC_EXEC_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_PIN_LOW_CYC     ((`RSC_PIN_LOW_MIN_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)

// Watchdog clock divider
`define RSC_WDOG_DIV        12

// User code space limits per memory size
`define RSC_LIMIT_8K        16'h1DFF
`define RSC_LIMIT_4K        16'h0FFF
`define RSC_LIMIT_2K        16'h07FF

// Reset values of the software enables
`define RSC_MON_EN_RST      1'b0
`define RSC_CLKLOSS_EN_RST  1'b0
`define RSC_COMP_EN_RST     1'b0

`endif

// ---- src/reset_source_pkg.sv ----
// Types for the reset source controller: phases, cause flags, bus request
// and the complete state record. Constants live in the defines header.
package reset_source_pkg;

	// Phases of the reset sequence
	typedef enum logic [1:0] {
		PH_RUN,
		PH_HOLD,
		PH_DELAY
	} phase_t;

	// Cause flags, bit 0 in the low end
	typedef struct packed {
		logic flash_error_flag;
		logic comparator_reset_flag_enable;
		logic software_reset_force_flag;
		logic watchdog_reset_flag;
		logic clock_loss_flag_enable;
		logic power_on_flag_monitor_enable;
		logic pin_reset_flag;
	} cause_flags_t;

	// Special-function register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sfr_req_t;

	// Program memory access attempts from the core
	typedef struct packed {
		logic        external_data_move_instr_req;
		logic [15:0] external_data_move_instr_addr;
		logic        code_table_read_instr_req;
		logic [15:0] code_table_read_instr_addr;
		logic        fetch_req;
		logic [15:0] fetch_addr;
	} mem_access_t;

	// Whole state of the controller
	typedef struct packed {
		phase_t            ph;
		cause_flags_t      flags;
		logic [6:0]        cnt;
		logic [3:0][2:0]   sy;
		logic [3:0]        lvl;
		logic              mon_en;
		logic              clkloss_en;
		logic              comp_en;
		logic              wdog_en;
		logic [3:0]        div;
		logic              wdog_tick;
		logic              sys_rst_n;
		logic              pin_oe_n;
		logic              pin_out;
		logic [7:0]        rdata;
	} rsc_state_t;

endpackage

// ---- verification/external_reset_circuit.sv ----
// Board around the reset pin: a pull-up and a switch to ground.
// Assumes the device drives the pin only through its active-low enable.
`timescale 1ns/100ps
module external_reset_circuit (
	input  wire logic clk,
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	output logic      pin_level
);
	logic switch_low;

	initial switch_low = 1'b0;

	// Pull-up wins unless either party pulls low
	assign pin_level = (switch_low || (!pin_oe_n && !pin_out)) ? 1'b0 : 1'b1;

	// Whole cycles only; callers never go below the guaranteed minimum
	task automatic press(input int cycles);
		@(posedge clk);
		#5 switch_low = 1'b1;
		repeat (cycles) @(posedge clk);
		#5 switch_low = 1'b0;
	endtask
endmodule // external_reset_circuit

// ---- verification/reset_source_controller_test.sv ----
// Self-checking bench for the reset source controller.
// Assumes a 20 MHz clock and the pin model on the reset line.
`timescale 1ns/100ps
`include "reset_source_defines.svh"
module reset_source_controller_test;
	import reset_source_pkg::*;
	localparam logic [15:0] LIM = `RSC_LIMIT_8K;
	logic        clk, rst_n, fwe, pin_level, pin_out, pin_oe_n, clt, comp;
	logic        wexp, wen, tick, cle, sme, sys_rst_n, wdis, slo;
	logic [7:0]  sfr_rdata;
	sfr_req_t    sfr;
	mem_access_t mem;
	int          n_fail, n_compared, cyc;

	reset_source_controller #(.USER_CODE_LIMIT(LIM)) u_reset_source_controller (
		.clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata), .mem(mem),
		.flash_write_enable(fwe), .rst_pin_in(pin_level), .rst_pin_out(pin_out),
		.rst_pin_oe_n(pin_oe_n), .clock_loss_timeout(clt), .comparator_out(comp),
		.supply_low(slo), .wdog_expired(wexp), .wdog_disable(wdis),
		.wdog_enable(wen), .wdog_tick(tick), .clock_loss_enable(cle),
		.supply_monitor_enable(sme), .sys_rst_n(sys_rst_n));

	external_reset_circuit u_external_reset_circuit (
		.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

	task automatic print_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		#5 sfr = '{8'hEF, d, 1'b1, 1'b0};
		@(posedge clk);
		#5 sfr.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] exp);
		@(posedge clk);
		#5 sfr.rd = 1'b1;
		@(posedge clk);
		#5 sfr.rd = 1'b0;
		@(posedge clk);
		#1 chk("reset_cause_reg", exp, sfr_rdata);
	endtask

	// Waits out one reset, then reads the cause back
	task automatic settle(input logic [7:0] exp, input logic exp_drv = 1'b0);
		int   n;
		logic driven;
		n = 0;
		driven = 1'b0;
		while (sys_rst_n !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (sys_rst_n !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1 n++;
			if (pin_oe_n !== 1'b1) driven = 1'b1;
		end
		chk("release_delay_ok", 8'h01, {7'h0, n >= 100});
		chk("pin_driven", {7'h0, exp_drv}, {7'h0, driven});
		rd(exp);
	endtask

	task automatic t_power;
		int n;
		n = 0;
		while (sys_rst_n !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		rd(8'h02);
		chk("wdog_enable", 8'h01, {7'h0, wen});
		n = 0;
		while (tick !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (tick !== 1'b1 && n < 40);
		chk("tick_period", 8'h0C, n[7:0]);
	endtask

	task automatic t_monitor;
		wr(8'h02);
		repeat (3) @(posedge clk);
		chk("monitor_enable", 8'h01, {7'h0, sme});
	endtask

	// A zero write does nothing; a one forces a reset
	task automatic t_soft;
		wr(8'h00);
		repeat (5) @(posedge clk);
		chk("no_reset", 8'h01, {7'h0, sys_rst_n});
		wr(8'h10);
		settle(8'h10);
		chk("monitor_kept", 8'h01, {7'h0, sme});
	endtask

	task automatic t_wdog;
		@(posedge clk);
		#5 wdis = 1'b1;
		@(posedge clk);
		#5 wdis = 1'b0;
		chk("wdog_disabled", 8'h00, {7'h0, wen});
		@(posedge clk);
		#5 wexp = 1'b1;
		@(posedge clk);
		#5 wexp = 1'b0;
		settle(8'h08);
		chk("wdog_enable", 8'h01, {7'h0, wen});
	endtask

	// Write without enable and access at the limit are legal
	task automatic t_flash;
		logic [15:0] a;
		for (int i = 0; i < 5; i++) begin
			a = (i == 1) ? LIM : LIM + 16'h0001;
			@(posedge clk);
			#5 fwe = (i != 0);
			mem = '{i < 3, a, i == 3, a, i == 4, a};
			@(posedge clk);
			#5 mem = '0;
			if (i < 2) begin
				repeat (5) @(posedge clk);
				chk("no_reset", 8'h01, {7'h0, sys_rst_n});
			end else
				settle(8'h40);
		end
	endtask

	task automatic t_pin;
		fork
			u_external_reset_circuit.press(300);
		join_none
		settle(8'h01);
	endtask

	task automatic t_comp;
		wr(8'h20);
		repeat (5) @(posedge clk);
		chk("no_reset", 8'h01, {7'h0, sys_rst_n});
		#5 comp = 1'b0;
		fork
			begin
				repeat (10) @(posedge clk);
				#5 comp = 1'b1;
			end
		join_none
		settle(8'h20);
	endtask

	task automatic t_clkloss;
		wr(8'h04);
		@(posedge clk);
		#1 chk("clock_loss_enable", 8'h01, {7'h0, cle});
		#4 clt = 1'b1;
		fork
			begin
				repeat (10) @(posedge clk);
				#5 clt = 1'b0;
			end
		join_none
		settle(8'h04);
		wr(8'h00);
		@(posedge clk);
		#1 chk("clock_loss_enable", 8'h00, {7'h0, cle});
	endtask

	// Supply dip: power flag, pin driven, monitor kept
	task automatic t_supply;
		@(posedge clk);
		#5 slo = 1'b1;
		repeat (10) @(posedge clk);
		#5 slo = 1'b0;
		settle(8'h02, 1'b1);
		chk("monitor_kept", 8'h01, {7'h0, sme});
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		n_fail = 0;
		n_compared = 0;
		cyc = 0;
		rst_n = 1'b0;
		sfr = '{8'hEF, 8'h00, 1'b0, 1'b0};
		mem = '0;
		fwe = 1'b0;
		clt = 1'b0;
		comp = 1'b1;
		wexp = 1'b0;
		wdis = 1'b0;
		slo = 1'b0;
		repeat (20) @(posedge clk);
		#5 rst_n = 1'b1;
		t_power();
		t_monitor();
		t_soft();
		t_wdog();
		t_flash();
		t_pin();
		t_comp();
		t_clkloss();
		t_supply();
		print_verdict();
	end
endmodule // reset_source_controller_test
